/* File: src/ppc_power_path.sv */
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module ppc_power_path #(
  parameter int RESP_CYCLES = ppc_pkg::RESP_CYC // Policy answer window
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog front end and internal policy processor
  input wire logic [11:0] cc_mv,
  input wire logic vbus_present,
  input wire logic int_contract,
  input wire logic [ppc_pkg::PROF_W-1:0] int_profile,
  input wire logic [1:0] int_level,
  input wire logic pe_request,
  // Power path pins
  output ppc_pkg::ppc_snk_t snk_pins,
  output ppc_pkg::ppc_src_t src_pins,
  output logic vconn_enable
);

  localparam logic [ppc_pkg::WD_W-1:0] WD_LAST =
    ppc_pkg::WD_W'(RESP_CYCLES - 1);
  localparam logic [ppc_pkg::PROF_N-1:0] SINK_CURRENT_SELECT_ONE =
    ppc_pkg::PROF_N'(1);

  // Whole state of the block
  typedef struct packed {
    ppc_pkg::ppc_st_t st;
    ppc_pkg::ppc_cc_t cls; // Committed CC class
    ppc_pkg::ppc_lvl_t lvl; // Source level in force
    ppc_pkg::ppc_lvl_t tgt; // Level waiting behind a gap
    logic [11:0] mv; // CC sample
    logic [ppc_pkg::GAP_W-1:0] cnt; // Gap counter
    logic [ppc_pkg::WD_W-1:0] wd; // Answer window counter
    logic wd_on;
    logic tout; // Sticky late-answer flag
    logic ext; // External controller owns policy
    logic role_src; // Requested role, sink after reset
    logic frs; // Fast swap request
    ppc_pkg::ppc_adv_t adv;
    logic [ppc_pkg::PROF_N:0] gpio; // Application value of sink pins
    logic [31:0] crc; // Held inverted so reset is the seed
    logic [31:0] prdata;
    ppc_pkg::ppc_snk_t snk;
    ppc_pkg::ppc_src_t src;
    logic vconn;
  } ppc_state_t;

  ppc_state_t s; // Current state
  ppc_state_t next_s; // Next state
  logic tick_main; // Sampling enable
  logic tick_lp; // Low-power enable
  logic wr; // APB write at access edge
  logic pol_wr; // Write of the policy register
  logic hit; // Address is mapped
  logic contract; // Negotiated result from the owner
  logic [ppc_pkg::PROF_W-1:0] cur_prof;
  ppc_pkg::ppc_lvl_t cur_tgt;
  logic [31:0] rd_mux;

  // Main and low-power rate enables
  ppc_tick_div #(.DIV(ppc_pkg::MAIN_DIV)) u_main_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_main)
  );
  ppc_tick_div #(.DIV(ppc_pkg::LP_DIV)) u_lp_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_lp)
  );

  // Map a two-bit level code; the unused code falls back to 5 V
  function automatic ppc_pkg::ppc_lvl_t lvl_of(input logic [1:0] c);
    ppc_pkg::ppc_lvl_t l;
    case (c)
      2'h1: l = ppc_pkg::LV_MID;
      2'h2: l = ppc_pkg::LV_TOP;
      default: l = ppc_pkg::LV_5V;
    endcase
    return l;
  endfunction : lvl_of

  // Classify CC against the thresholds of the current advert
  function automatic ppc_pkg::ppc_cc_t cc_classify(
    input logic [11:0] mv,
    input ppc_pkg::ppc_adv_t adv,
    input ppc_pkg::ppc_cc_t prev
  );
    logic [11:0] ra;
    logic [11:0] rd;
    logic [11:0] op;
    ppc_pkg::ppc_cc_t c;
    case (adv)
      ppc_pkg::ADV_1A5: begin
        ra = ppc_pkg::RA_1A5;
        rd = ppc_pkg::RD_LOW;
        op = ppc_pkg::OPEN_LOW;
      end
      ppc_pkg::ADV_3A: begin
        ra = ppc_pkg::RA_3A;
        rd = ppc_pkg::RD_3A;
        op = ppc_pkg::OPEN_3A;
      end
      default: begin
        ra = ppc_pkg::RA_DEF;
        rd = ppc_pkg::RD_LOW;
        op = ppc_pkg::OPEN_LOW;
      end
    endcase
    // The band between sink and open keeps the old class as hysteresis
    if (mv < ra) begin
      c = ppc_pkg::CC_CABLE;
    end else if (mv < rd) begin
      c = ppc_pkg::CC_SINK;
    end else if (mv >= op) begin
      c = ppc_pkg::CC_OPEN;
    end else begin
      c = prev;
    end
    return c;
  endfunction : cc_classify

  // One byte into the reflected message check, low bit first
  function automatic logic [31:0] crc_byte(
    input logic [31:0] c,
    input logic [7:0] d
  );
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ ppc_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  // Bus decode; the slave never waits
  assign wr = psel && penable && pwrite;
  assign pol_wr = wr && (paddr == ppc_pkg::OFS_POLICY);
  assign hit = (paddr == ppc_pkg::OFS_CTRL) ||
    (paddr == ppc_pkg::OFS_POLICY) || (paddr == ppc_pkg::OFS_STATUS) ||
    (paddr == ppc_pkg::OFS_GPIO) || (paddr == ppc_pkg::OFS_CRC_DATA) ||
    (paddr == ppc_pkg::OFS_CRC);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Policy results come only from whoever owns the policy
  assign contract = s.ext ? pol_wr : int_contract;
  assign cur_prof = s.ext ? pwdata[ppc_pkg::POL_PROF+:ppc_pkg::PROF_W]
    : int_profile;
  assign cur_tgt = s.ext ? lvl_of(pwdata[ppc_pkg::POL_LVL+:2])
    : lvl_of(int_level);

  // Read data selection, sampled in the setup cycle
  always_comb begin
    rd_mux = '0;
    case (paddr)
      ppc_pkg::OFS_CTRL: begin
        rd_mux[ppc_pkg::CTRL_EXT] = s.ext;
        rd_mux[ppc_pkg::CTRL_SRC] = s.role_src;
        rd_mux[ppc_pkg::CTRL_FRS] = s.frs;
        rd_mux[ppc_pkg::CTRL_ADV+:2] = s.adv;
      end
      ppc_pkg::OFS_POLICY: begin
        rd_mux[ppc_pkg::POL_LVL+:2] = s.lvl;
      end
      ppc_pkg::OFS_STATUS: begin
        rd_mux[ppc_pkg::STAT_CLS+:2] = s.cls;
        rd_mux[ppc_pkg::STAT_LVL+:2] = s.lvl;
        rd_mux[ppc_pkg::STAT_ST+:3] = s.st;
        rd_mux[ppc_pkg::STAT_TOUT] = s.tout;
      end
      ppc_pkg::OFS_GPIO: rd_mux[ppc_pkg::PROF_N:0] = s.gpio;
      ppc_pkg::OFS_CRC: rd_mux = s.crc;
      default: rd_mux = '0; // Unmapped and write-only read as zero
    endcase
  end

  // Next state: bus, sampling, answer window, then the power sequencer
  always_comb begin
    next_s = s;
    if (psel && !penable && !pwrite) begin
      next_s.prdata = rd_mux;
    end
    // Register writes
    if (wr) begin
      case (paddr)
        ppc_pkg::OFS_CTRL: begin
          next_s.ext = pwdata[ppc_pkg::CTRL_EXT];
          next_s.role_src = pwdata[ppc_pkg::CTRL_SRC];
          next_s.frs = pwdata[ppc_pkg::CTRL_FRS];
          next_s.adv = ppc_pkg::ppc_adv_t'(pwdata[ppc_pkg::CTRL_ADV+:2]);
        end
        ppc_pkg::OFS_POLICY: next_s.wd_on = 1'b0;
        ppc_pkg::OFS_STATUS: begin
          if (pwdata[ppc_pkg::STAT_TOUT]) begin
            next_s.tout = 1'b0;
          end
        end
        ppc_pkg::OFS_GPIO: next_s.gpio = pwdata[ppc_pkg::PROF_N:0];
        ppc_pkg::OFS_CRC_DATA: begin
          next_s.crc = ~crc_byte(~s.crc, pwdata[7:0]);
        end
        ppc_pkg::OFS_CRC: next_s.crc = '0; // Back to the seed
        default: ;
      endcase
    end
    // CC sampled at the main rate, committed at the low-power rate
    if (tick_main) begin
      next_s.mv = cc_mv;
    end
    if (tick_lp) begin
      next_s.cls = cc_classify(s.mv, s.adv, s.cls);
    end
    // Late answers only flag after the full window; the set wins a clear
    if (pe_request && s.ext) begin
      next_s.wd_on = 1'b1;
      next_s.wd = '0;
    end else if (s.wd_on && !pol_wr) begin
      if (s.wd == WD_LAST) begin
        next_s.tout = 1'b1;
        next_s.wd_on = 1'b0;
      end else begin
        next_s.wd = s.wd + 1'b1;
      end
    end
    // Power sequencer
    case (s.st)
      ppc_pkg::S_IDLE: begin
        if (!s.role_src && vbus_present) begin
          next_s.st = ppc_pkg::S_SNK_WAIT;
        end else if (s.role_src && s.cls == ppc_pkg::CC_SINK) begin
          next_s.st = ppc_pkg::S_SRC_ON;
          next_s.lvl = ppc_pkg::LV_5V;
          next_s.src.source_supply_enable = 1'b1;
          next_s.vconn = 1'b1;
        end
      end
      ppc_pkg::S_SNK_WAIT, ppc_pkg::S_SNK_GAP, ppc_pkg::S_SNK_ON: begin
        if (!vbus_present || s.role_src) begin
          next_s.st = ppc_pkg::S_IDLE;
          next_s.snk = '0;
        end else if (contract) begin
          // Profile shown first, load follows after the gap
          next_s.snk.sink_current_select = SINK_CURRENT_SELECT_ONE << cur_prof;
          next_s.cnt = '0;
          next_s.st = ppc_pkg::S_SNK_GAP;
        end else if (s.st == ppc_pkg::S_SNK_GAP) begin
          if (s.cnt == ppc_pkg::GAP_LAST) begin
            next_s.snk.load_enable = 1'b1;
            next_s.st = ppc_pkg::S_SNK_ON;
          end else begin
            next_s.cnt = s.cnt + 1'b1;
          end
        end
      end
      ppc_pkg::S_SRC_ON, ppc_pkg::S_SRC_GAP: begin
        if (s.cls == ppc_pkg::CC_OPEN || !s.role_src) begin
          next_s.st = ppc_pkg::S_IDLE;
          next_s.src = '0;
          next_s.vconn = 1'b0;
          next_s.lvl = ppc_pkg::LV_5V;
        end else if (s.frs) begin
          // Sink side comes up before the supply is released
          next_s.frs = 1'b0;
          next_s.snk.sink_current_select = SINK_CURRENT_SELECT_ONE;
          next_s.cnt = '0;
          next_s.st = ppc_pkg::S_FRS;
        end else if (s.st == ppc_pkg::S_SRC_GAP) begin
          if (s.cnt == ppc_pkg::GAP_LAST) begin
            next_s.src.source_mid_voltage_select =
              (s.tgt == ppc_pkg::LV_MID);
            next_s.src.source_top_voltage_select =
              (s.tgt == ppc_pkg::LV_TOP);
            next_s.lvl = s.tgt;
            next_s.st = ppc_pkg::S_SRC_ON;
          end else begin
            next_s.cnt = s.cnt + 1'b1;
          end
        end else if (contract && cur_tgt != s.lvl) begin
          next_s.tgt = cur_tgt;
          if (s.lvl == ppc_pkg::LV_5V || cur_tgt == ppc_pkg::LV_5V) begin
            // Only one pin moves, so no ordering is needed
            next_s.src.source_mid_voltage_select =
              (cur_tgt == ppc_pkg::LV_MID);
            next_s.src.source_top_voltage_select =
              (cur_tgt == ppc_pkg::LV_TOP);
            next_s.lvl = cur_tgt;
          end else begin
            next_s.src.source_mid_voltage_select = 1'b0;
            next_s.src.source_top_voltage_select = 1'b0;
            next_s.cnt = '0;
            next_s.st = ppc_pkg::S_SRC_GAP;
          end
        end
      end
      ppc_pkg::S_FRS: begin
        if (!s.snk.load_enable) begin
          if (s.cnt == ppc_pkg::GAP_LAST) begin
            next_s.snk.load_enable = 1'b1;
          end else begin
            next_s.cnt = s.cnt + 1'b1;
          end
        end else begin
          next_s.src = '0;
          next_s.vconn = 1'b0;
          next_s.lvl = ppc_pkg::LV_5V;
          next_s.role_src = 1'b0;
          next_s.st = ppc_pkg::S_SNK_ON;
        end
      end
      default: next_s.st = ppc_pkg::S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // In the sink role the power logic owns the sink pins
  assign snk_pins = s.role_src ? ppc_pkg::ppc_snk_t'(s.gpio) : s.snk;
  assign src_pins = s.src;
  assign vconn_enable = s.vconn;
  assign prdata = s.prdata;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence snk_enter_gap;
    contract && !s.role_src && vbus_present &&
      (s.st == ppc_pkg::S_SNK_WAIT);
  endsequence

  sequence src_detach;
    (s.st == ppc_pkg::S_SRC_ON) && (s.cls == ppc_pkg::CC_OPEN);
  endsequence

  a_load_after_sink_current_select: assert property (
    $rose(s.snk.load_enable) |-> $past(s.snk.sink_current_select) != '0)
    else $error("load enable rose without a current select");

  a_gap_bound: assert property (s.cnt <= ppc_pkg::GAP_LAST)
    else $error("select gap counter ran past its limit");

  a_sink_start: assert property (
    snk_enter_gap |=> s.snk.sink_current_select ==
      (SINK_CURRENT_SELECT_ONE << $past(cur_prof)) && !$rose(s.snk.load_enable))
    else $error("profile select not shown at contract");

  a_src_attach: assert property (
    (s.st == ppc_pkg::S_IDLE) ##1 (s.st == ppc_pkg::S_SRC_ON) |->
      s.src.source_supply_enable && s.vconn &&
      !s.src.source_mid_voltage_select && !s.src.source_top_voltage_select)
    else $error("source attach not at 5 V with VCONN");

  a_sel_onehot: assert property (
    (s.src.source_mid_voltage_select || s.src.source_top_voltage_select)
      |-> s.src.source_supply_enable && !(s.src.source_mid_voltage_select
      && s.src.source_top_voltage_select))
    else $error("voltage selects not one-hot under supply");

  a_break_make: assert property (
    $rose(s.src.source_top_voltage_select) |->
      !$past(s.src.source_mid_voltage_select))
    else $error("top select rose while mid select was high");

  a_detach_clear: assert property (
    src_detach |=> (s.st == ppc_pkg::S_IDLE) && (s.src == '0) && !s.vconn)
    else $error("detach left power pins driven");

  a_frs_overlap: assert property (
    $fell(s.src.source_supply_enable) && $past(s.st == ppc_pkg::S_FRS)
      |-> s.snk.load_enable)
    else $error("supply dropped before load enable in fast swap");

  a_late_flag: assert property (
    $rose(s.tout) |-> $past(s.wd) == WD_LAST)
    else $error("late answer flagged before the full window");

  a_sink_owned: assert property (
    !s.role_src |-> snk_pins == s.snk)
    else $error("sink pins not owned by power logic");

  a_cc_3a: assert property (
    tick_lp && (s.adv == ppc_pkg::ADV_3A) && (s.mv >= ppc_pkg::OPEN_3A)
      |=> s.cls == ppc_pkg::CC_OPEN)
    else $error("open line not recognised at 3 A advert");

endmodule : ppc_power_path

/* File: src/ppc_pkg.sv */
package ppc_pkg;

  // Clock period and the timing figures it turns into cycles
  localparam int CLK_NS = 8;
  localparam int GAP_NS = 12500; // Longest select gap, 12.5 us
  localparam int GAP_CYC = GAP_NS / CLK_NS; // Longest time: rounded down
  localparam int RESP_NS = 10000000; // Policy answer window, 10 ms
  localparam int RESP_CYC = RESP_NS / CLK_NS;
  localparam int GAP_W = 11;
  localparam int WD_W = 21;
  localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(GAP_CYC - 1);

  // Slow enables standing in for the 12 MHz and 32 kHz clocks
  localparam int MAIN_DIV = 10;
  localparam int LP_DIV = 3814;
  localparam int DIV_W = 12;

  // Number of sink profiles, one current select line each
  localparam int PROF_N = 4;
  localparam int PROF_W = 2;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_POLICY = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_GPIO = 8'h0C;
  localparam logic [7:0] OFS_CRC_DATA = 8'h10;
  localparam logic [7:0] OFS_CRC = 8'h14;

  // Field positions
  localparam int CTRL_EXT = 0;
  localparam int CTRL_SRC = 1;
  localparam int CTRL_FRS = 2;
  localparam int CTRL_ADV = 4;
  localparam int POL_PROF = 0;
  localparam int POL_LVL = 2;
  localparam int STAT_CLS = 0;
  localparam int STAT_LVL = 2;
  localparam int STAT_ST = 4;
  localparam int STAT_TOUT = 7;

  // CC thresholds in millivolts
  localparam logic [11:0] RA_DEF = 12'h0C8; // 0.20 V
  localparam logic [11:0] RA_1A5 = 12'h190; // 0.40 V
  localparam logic [11:0] RA_3A = 12'h320; // 0.80 V
  localparam logic [11:0] RD_LOW = 12'h640; // 1.60 V
  localparam logic [11:0] RD_3A = 12'hA28; // 2.60 V
  localparam logic [11:0] OPEN_LOW = 12'h672; // 1.65 V
  localparam logic [11:0] OPEN_3A = 12'hABE; // 2.75 V

  // Message check polynomial, reflected form
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;

  typedef enum logic [1:0] {ADV_DEF, ADV_1A5, ADV_3A} ppc_adv_t;
  typedef enum logic [1:0] {
    CC_OPEN, CC_SINK, CC_CABLE
  } ppc_cc_t;
  typedef enum logic [1:0] {LV_5V, LV_MID, LV_TOP} ppc_lvl_t;
  typedef enum logic [2:0] {
    S_IDLE, S_SNK_WAIT, S_SNK_GAP, S_SNK_ON, S_SRC_ON, S_SRC_GAP, S_FRS
  } ppc_st_t;

  // Sink side power path pins
  typedef struct packed {
    logic [PROF_N-1:0] sink_current_select;
    logic load_enable;
  } ppc_snk_t;

  // Source side supply pins
  typedef struct packed {
    logic source_supply_enable;
    logic source_mid_voltage_select;
    logic source_top_voltage_select;
  } ppc_src_t;

  // Divider state
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } ppc_div_t;

endpackage : ppc_pkg

/* File: src/ppc_tick_div.sv */
`timescale 1ns/10ps
// One-cycle enable every DIV clocks
module ppc_tick_div #(
  parameter int DIV = ppc_pkg::MAIN_DIV
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Enable pulse
  output logic tick
);

  localparam logic [ppc_pkg::DIV_W-1:0] LAST = ppc_pkg::DIV_W'(DIV - 1);

  ppc_pkg::ppc_div_t s; // Current state
  ppc_pkg::ppc_div_t next_s; // Next state

  // Count up through the period; the tick is registered so it is glitch free
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == LAST) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule : ppc_tick_div

/* File: verification/ppc_partner.sv */
`timescale 1ns/10ps
// Far side of the port: the partner's pull on CC and its VBUS supply
module ppc_partner (
  // Clock
  input wire logic pclk,
  // Bench commands
  input wire logic want_src,
  input wire logic [11:0] want_mv,
  // Port pins seen by the controller
  output logic [11:0] cc_mv,
  output logic vbus_present
);
  // Pins move only on the clock, so no input ever changes between sample edges
  always_ff @(posedge pclk) begin
    cc_mv <= want_mv;
    vbus_present <= want_src;
  end
endmodule : ppc_partner

/* File: verification/ppc_power_path_tb.sv */
`timescale 1ns/10ps
// Self-checking bench for the power path controller
module ppc_power_path_tb;
  localparam int RESP = 50; // Short answer window keeps the run brief
  localparam int SETTLE = 7700; // Two low-rate classification ticks
  // Clock, reset and bus
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Policy processor side and partner commands
  logic int_contract = 1'b0;
  logic [1:0] int_profile = 2'h0;
  logic [1:0] int_level = 2'h0;
  logic pe_request = 1'b0;
  logic want_src = 1'b0;
  logic [11:0] want_mv = 12'hBB8; // Open line at start
  logic [11:0] cc_mv;
  logic vbus_present;
  // Power pins
  ppc_pkg::ppc_snk_t snk_pins;
  ppc_pkg::ppc_src_t src_pins;
  logic vconn_enable;
  // Score and random state
  int fails = 0;
  int checked = 0;
  logic [31:0] seed = 32'h787CC0AE;

  // Clock of 8 ns
  always #4 pclk = ~pclk;

  ppc_partner partner (.pclk(pclk), .want_src(want_src),
    .want_mv(want_mv), .cc_mv(cc_mv), .vbus_present(vbus_present));

  ppc_power_path #(.RESP_CYCLES(RESP)) dut (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cc_mv(cc_mv), .vbus_present(vbus_present),
    .int_contract(int_contract), .int_profile(int_profile),
    .int_level(int_level), .pe_request(pe_request), .snk_pins(snk_pins),
    .src_pins(src_pins), .vconn_enable(vconn_enable));

  // Next random value below a bound, from the bench's shift register
  function automatic int rnd(input int lim);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return int'(seed[15:0]) % lim;
  endfunction : rnd

  // CC thresholds per advert: 0 cable, 1 sink pull-down, 2 open line
  function automatic logic [11:0] thr(input int adv, input int which);
    if (which == 0)
      return adv == 2 ? 12'h320 : (adv == 1 ? 12'h190 : 12'h0C8);
    if (which == 1)
      return adv == 2 ? 12'hA28 : 12'h640;
    return adv == 2 ? 12'hABE : 12'h672;
  endfunction : thr

  // Expected class; the dead band keeps the previous one
  function automatic logic [1:0] cls_of(input int adv, input logic [11:0] mv,
                                        input logic [1:0] prev);
    if (mv < thr(adv, 0)) return 2'h2;
    if (mv < thr(adv, 1)) return 2'h1;
    if (mv >= thr(adv, 2)) return 2'h0;
    return prev;
  endfunction : cls_of

  // One compare, counted
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // One APB transfer; the request holds until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk("pready", 32'h1, 32'h0);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  // Read a register and compare the masked bits
  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    chk(what, x, r & m);
  endtask : rdchk

  // Policy result pulse; returns one step after the edge that took it
  task automatic contract(input logic [1:0] p, input logic [1:0] l);
    @(posedge pclk);
    int_contract <= 1'b1;
    int_profile <= p;
    int_level <= l;
    @(posedge pclk);
    int_contract <= 1'b0;
    #1;
  endtask : contract

  task automatic pe_pulse;
    @(posedge pclk);
    pe_request <= 1'b1;
    @(posedge pclk);
    pe_request <= 1'b0;
  endtask : pe_pulse

  // Verdict, the single end of the run
  task automatic end_of_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // Watchdog sized above the expected run of about 90000 cycles
  initial begin
    cyc(96000);
    fails++;
    $display("ERROR watchdog expected finish seen hang");
    end_of_test();
  end

  // Main sequence
  initial begin
    int v;
    logic [11:0] mv;
    logic [1:0] prev;
    logic [1:0] p;
    logic [31:0] r;
    logic e;
    cyc(5);
    presetn <= 1'b1;
    // Reset state and an unmapped address
    @(posedge pclk);
    #1;
    chk("reset pins", 32'h0, {24'h0, snk_pins, src_pins});
    rdchk("reset status", ppc_pkg::OFS_STATUS, 32'hFF, 32'h0);
    apb(8'h20, 1'b0, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    $display("test reset done");
    // Sink attach: select first, load after the gap
    v = rnd(4);
    p = v[1:0];
    want_src <= 1'b1;
    cyc(3);
    contract(p, 2'h0);
    chk("sink select", {27'h0, 4'h1 << p, 1'b0}, {27'h0, snk_pins});
    // Load rises GAP_CYC edges after the edge that took the contract
    cyc(ppc_pkg::GAP_CYC - 1);
    #1;
    chk("load early", {27'h0, 4'h1 << p, 1'b0}, {27'h0, snk_pins});
    @(posedge pclk);
    #1;
    chk("load on", {27'h0, 4'h1 << p, 1'b1}, {27'h0, snk_pins});
    wr(ppc_pkg::OFS_GPIO, 32'h1F);
    #1;
    chk("gpio blocked", {27'h0, 4'h1 << p, 1'b1}, {27'h0, snk_pins});
    want_src <= 1'b0;
    cyc(3);
    #1;
    chk("sink detach", 32'h0, {27'h0, snk_pins});
    $display("test sink done");
    // CC classification per advert, corners and random values
    prev = 2'h0;
    for (int adv = 0; adv < 3; adv++) begin
      wr(ppc_pkg::OFS_CTRL, adv << 4);
      for (int k = 0; k < 3; k++) begin
        v = rnd(int'(thr(adv, 1) - thr(adv, 0)));
        mv = k == 0 ? thr(adv, 0) - 12'h001 :
             (k == 1 ? thr(adv, 0) + 12'(v) : thr(adv, 2));
        want_mv <= mv;
        cyc(SETTLE);
        prev = cls_of(adv, mv, prev);
        rdchk("cc class", ppc_pkg::OFS_STATUS, 32'h3, {30'h0, prev});
      end
    end
    $display("test classify done");
    // Source attach and level moves
    wr(ppc_pkg::OFS_CTRL, 32'h2);
    want_mv <= 12'h3E8;
    cyc(SETTLE);
    #1;
    chk("src attach", 32'h9, {28'h0, src_pins, vconn_enable});
    chk("gpio source", 32'h1F, {27'h0, snk_pins});
    contract(2'h0, ppc_pkg::LV_MID);
    chk("src mid", 32'h6, {29'h0, src_pins});
    contract(2'h0, ppc_pkg::LV_TOP);
    chk("src break", 32'h4, {29'h0, src_pins});
    cyc(ppc_pkg::GAP_CYC - 1);
    #1;
    chk("src gap", 32'h4, {29'h0, src_pins});
    @(posedge pclk);
    #1;
    chk("src top", 32'h5, {29'h0, src_pins});
    contract(2'h0, 2'h3);
    chk("src back 5v", 32'h4, {29'h0, src_pins});
    wr(ppc_pkg::OFS_CTRL, 32'h0);
    cyc(2);
    #1;
    chk("src off", 32'h0, {28'h0, src_pins, vconn_enable});
    // Re-attach as source with a fast swap pending; CC still shows a sink
    wr(ppc_pkg::OFS_CTRL, 32'h6);
    cyc(ppc_pkg::GAP_CYC + 2);
    #1;
    chk("frs overlap", 32'h9, {28'h0, src_pins, vconn_enable});
    @(posedge pclk);
    #1;
    chk("frs swap", 32'h3, {27'h0, snk_pins});
    chk("frs supply off", 32'h0, {28'h0, src_pins, vconn_enable});
    // Source attach again, then the sink's pull-down goes away
    wr(ppc_pkg::OFS_CTRL, 32'h2);
    want_mv <= 12'hBB8;
    cyc(SETTLE);
    #1;
    chk("src cc open", 32'h0, {28'h0, src_pins, vconn_enable});
    $display("test source done");
    // External policy answer window
    wr(ppc_pkg::OFS_CTRL, 32'h1);
    pe_pulse();
    cyc(5);
    wr(ppc_pkg::OFS_POLICY, 32'h0);
    cyc(RESP + 10);
    rdchk("late clear", ppc_pkg::OFS_STATUS, 32'h80, 32'h0);
    pe_pulse();
    cyc(RESP + 10);
    rdchk("late set", ppc_pkg::OFS_STATUS, 32'h80, 32'h80);
    wr(ppc_pkg::OFS_STATUS, 32'h80);
    rdchk("late w1c", ppc_pkg::OFS_STATUS, 32'h80, 32'h0);
    $display("test policy done");
    end_of_test();
  end
endmodule : ppc_power_path_tb
